/* design/csot_clock_select.sv */
// Purpose: Clock source selection, dividers, oscillator trims and table read
// Assumes: Source clocks arrive as pins and become one-cycle enables
// Notes:   All derived clocks except the clock output pin are enable pulses on i_clk_sys
`timescale 1ns/1ns
module csot_clock_select #(
  parameter logic [15:0] SILICON_ID      = 16'h5a5a, // Arbitrary identifier
  parameter logic [7:0]  FAST_TRIM_CAL   = 8'h10,
  parameter logic [7:0]  SLOW_TRIM_CAL   = 8'h08,
  parameter int          WAKE_SLOW_TICKS = 1024
) (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  // Register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [7:0]                  o_rdata,
  // Source clock pins and power state
  input  wire logic                   i_fast_osc,
  input  wire logic                   i_ext_crystal,
  input  wire logic                   i_external_clock_input,
  input  wire logic                   i_sleep,
  // Derived clock enables
  output csot_pkg::csot_ticks_t       o_ticks,
  output logic                        o_slow_tick,
  output logic                        o_wakeup,
  // Clock output pin
  output logic                        o_clock_output_pin,
  output logic                        o_clock_output_pin_oe,
  // Oscillator trims and table status
  output csot_pkg::csot_fast_trim_t   o_fast_osc_trim,
  output csot_pkg::csot_slow_trim_t   o_slow_osc_trim,
  output logic                        o_table_busy
);
  initial
  begin
    if (WAKE_SLOW_TICKS < 2 || WAKE_SLOW_TICKS > 65535)
      $error("csot_clock_select: WAKE_SLOW_TICKS out of range");
  end

  // Pin synchronisers: stage one feeds only stage two
  logic [2:0] pin_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_edge;
  assign pin_in = {i_external_clock_input, i_ext_crystal, i_fast_osc};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge i_clk_sys or posedge i_reset)
      begin
        if (i_reset)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end
        else
        begin
          sync1[g] <= pin_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
      assign pin_edge[g] = sync2[g] & ~sync3[g];
    end
  endgenerate

  // Register file state
  logic [7:0]                cpu_cfg;
  logic [7:0]                timer_cfg;
  logic [7:0]                aux_cfg;
  csot_pkg::csot_fast_trim_t fast_trim;
  csot_pkg::csot_slow_trim_t slow_trim;
  logic [7:0]                param_mem [csot_pkg::PARAM_BYTES];
  csot_pkg::csot_state_t     state;
  logic [2:0]                copy_idx;
  logic [2:0]                table_sel;
  logic [7:0]                next_cpu_cfg;
  logic [7:0]                next_timer_cfg;
  logic [7:0]                next_aux_cfg;
  csot_pkg::csot_fast_trim_t next_fast_trim;
  csot_pkg::csot_slow_trim_t next_slow_trim;
  logic [7:0]                next_param_mem [csot_pkg::PARAM_BYTES];
  csot_pkg::csot_state_t     next_state;
  logic [2:0]                next_copy_idx;
  logic [2:0]                next_table_sel;
  logic [7:0]                next_rdata;
  logic                      param_hit;
  logic [2:0]                param_idx;

  // Fixed table contents; only table 0 carries data here
  function automatic logic [7:0] table_byte(input logic [2:0] tsel, input logic [2:0] idx);
    table_byte = 8'h00;
    if (tsel == 3'h0 && idx == 3'h0)
      table_byte = SILICON_ID[15:8]; // High byte first
    else if (tsel == 3'h0 && idx == 3'h1)
      table_byte = SILICON_ID[7:0];
  endfunction : table_byte

  assign param_hit = (i_addr[7:3] == csot_pkg::ADDR_PARAM_BASE[7:3]);
  assign param_idx = i_addr[2:0];

  // Register writes, boot load and table copy engine
  always_comb
  begin
    next_cpu_cfg   = cpu_cfg;
    next_timer_cfg = timer_cfg;
    next_aux_cfg   = aux_cfg;
    next_fast_trim = fast_trim;
    next_slow_trim = slow_trim;
    next_param_mem = param_mem;
    next_state     = state;
    next_copy_idx  = copy_idx;
    next_table_sel = table_sel;
    case (state)
      csot_pkg::ST_BOOT:
      begin
        next_fast_trim         = FAST_TRIM_CAL;      // Factory load at boot
        next_fast_trim.foffset = 3'h0;               // Fine offset left at zero
        next_slow_trim         = SLOW_TRIM_CAL;
        next_slow_trim.reserved = 1'b0;
        next_state             = csot_pkg::ST_IDLE;
      end
      csot_pkg::ST_IDLE:
      begin
        if (i_wr)
        begin
          case (i_addr)
            csot_pkg::ADDR_CPU_CFG:   next_cpu_cfg   = i_wdata;
            csot_pkg::ADDR_TIMER_CFG: next_timer_cfg = i_wdata;
            csot_pkg::ADDR_AUX_CFG:
            begin
              next_aux_cfg = i_wdata;
              if (i_wdata[2:0] == csot_pkg::CPU_DIV_RESERVED)
                next_aux_cfg[2:0] = aux_cfg[2:0]; // Exponent 6 is not offered
            end
            csot_pkg::ADDR_FAST_TRIM: next_fast_trim = i_wdata;
            csot_pkg::ADDR_SLOW_TRIM:
            begin
              next_slow_trim          = i_wdata;
              next_slow_trim.reserved = 1'b0;
            end
            csot_pkg::ADDR_CALL:
            begin
              if (i_wdata == csot_pkg::OP_TABLE_READ &&
                  param_mem[csot_pkg::KEY_IDX] == csot_pkg::SUPERVISORY_KEY)
              begin
                next_table_sel = param_mem[csot_pkg::TABLE_SEL_IDX][2:0]; // Upper bits ignored
                next_copy_idx  = 3'h0;
                next_state     = csot_pkg::ST_COPY;
              end
            end
            default:
            begin
              if (param_hit)
                next_param_mem[param_idx] = i_wdata;
            end
          endcase
        end
      end
      csot_pkg::ST_COPY:
      begin
        next_param_mem[copy_idx] = table_byte(table_sel, copy_idx); // Eight bytes
        next_copy_idx            = copy_idx + 3'h1;
        if (copy_idx == 3'h7)
          next_state = csot_pkg::ST_IDLE;
      end
      default: next_state = csot_pkg::ST_IDLE;
    endcase
  end

  // Read data stands for one cycle only
  always_comb
  begin
    next_rdata = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        csot_pkg::ADDR_CPU_CFG:   next_rdata = cpu_cfg;
        csot_pkg::ADDR_TIMER_CFG: next_rdata = timer_cfg;
        csot_pkg::ADDR_AUX_CFG:   next_rdata = aux_cfg;
        csot_pkg::ADDR_FAST_TRIM: next_rdata = fast_trim;
        csot_pkg::ADDR_SLOW_TRIM: next_rdata = slow_trim;
        csot_pkg::ADDR_STATUS:
          next_rdata = {4'h0, o_clock_output_pin, i_sleep, state == csot_pkg::ST_BOOT,
                        state == csot_pkg::ST_COPY};
        default:
        begin
          if (param_hit)
            next_rdata = param_mem[param_idx];
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      cpu_cfg   <= csot_pkg::CPU_CFG_RST;
      timer_cfg <= csot_pkg::TIMER_CFG_RST;
      aux_cfg   <= csot_pkg::AUX_CFG_RST;
      fast_trim <= csot_pkg::TRIM_RST;
      slow_trim <= csot_pkg::TRIM_RST;
      param_mem <= '{default: 8'h00};
      state     <= csot_pkg::ST_BOOT;
      copy_idx  <= 3'h0;
      table_sel <= 3'h0;
      o_rdata   <= 8'h00;
    end
    else
    begin
      cpu_cfg   <= next_cpu_cfg;
      timer_cfg <= next_timer_cfg;
      aux_cfg   <= next_aux_cfg;
      fast_trim <= next_fast_trim;
      slow_trim <= next_slow_trim;
      param_mem <= next_param_mem;
      state     <= next_state;
      copy_idx  <= next_copy_idx;
      table_sel <= next_table_sel;
      o_rdata   <= next_rdata;
    end
  end

  // Slow oscillator and wakeup; sleep never stops this counter
  logic [15:0] slow_cnt;
  logic [15:0] wake_cnt;
  logic [15:0] next_slow_cnt;
  logic [15:0] next_wake_cnt;
  logic        next_slow_tick;
  logic        next_wakeup;
  logic        filt_level;
  logic        next_filt_level;
  logic        filt_edge;

  always_comb
  begin
    next_slow_cnt  = slow_cnt + 16'h0001;
    next_wake_cnt  = wake_cnt;
    next_slow_tick = 1'b0;
    next_wakeup    = 1'b0;
    if (slow_cnt == 16'(csot_pkg::SLOW_DIV_CYC - 1))
    begin
      next_slow_cnt  = 16'h0000;
      next_slow_tick = 1'b1; // Nominal slow oscillator
      next_wake_cnt  = wake_cnt + 16'h0001;
      if (wake_cnt == 16'(WAKE_SLOW_TICKS - 1))
      begin
        next_wake_cnt = 16'h0000;
        next_wakeup   = 1'b1; // Periodic wakeup from the slow clock
      end
    end
    // Fast transient filter: accept a level after two equal samples
    next_filt_level = filt_level;
    if (!aux_cfg[csot_pkg::AUX_FILT_BIT])
      next_filt_level = sync2[2];
    else if (sync2[2] == sync3[2])
      next_filt_level = sync2[2];
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      slow_cnt    <= 16'h0000;
      wake_cnt    <= 16'h0000;
      o_slow_tick <= 1'b0;
      o_wakeup    <= 1'b0;
      filt_level  <= 1'b0;
    end
    else
    begin
      slow_cnt    <= next_slow_cnt;
      wake_cnt    <= next_wake_cnt;
      o_slow_tick <= next_slow_tick;
      o_wakeup    <= next_wakeup;
      filt_level  <= next_filt_level;
    end
  end

  // Source enables; the slow source is withheld from timers in sleep
  logic src_fast;
  logic src_xtal;
  logic src_slow;
  assign src_fast  = pin_edge[0]; // Fast oscillator macro output
  assign src_xtal  = pin_edge[1];
  assign src_slow  = o_slow_tick & ~i_sleep;
  assign filt_edge = next_filt_level & ~filt_level;

  // Independent dividers for the processor, serial bus and interval clocks
  logic       cpu_src;
  logic       sbus_src;
  logic       sbus_nodiv;
  logic       itmr_src;
  logic [7:0] cpu_divisor;
  logic [2:0] itmr_divisor;
  logic       cpu_tick;
  logic       sbus_tick;
  logic       itmr_tick;
  logic       cap_tick;
  logic       next_cap_tick;
  assign cpu_src     = cpu_cfg[csot_pkg::CPU_SEL_BIT] ? src_xtal : src_fast;
  assign cpu_divisor = 8'h01 << aux_cfg[2:0]; // 2^n with n 0..5 or 7
  assign sbus_src    = cpu_cfg[csot_pkg::SBUS_SEL_BIT] ? src_xtal : src_fast;
  // Halving is always on for the fast source
  assign sbus_nodiv  = cpu_cfg[csot_pkg::SBUS_SEL_BIT] & cpu_cfg[csot_pkg::SBUS_NODIV_BIT];
  assign itmr_divisor = {1'b0, timer_cfg[3:2]} + 3'h1; // Prescale 1..4

  // Capture and interval source selection
  always_comb
  begin
    case (csot_pkg::csot_src_t'(timer_cfg[5:4]))
      csot_pkg::SRC_XTAL: next_cap_tick = src_xtal;
      csot_pkg::SRC_FAST: next_cap_tick = src_fast;
      csot_pkg::SRC_SLOW: next_cap_tick = src_slow;
      default:            next_cap_tick = 1'b0; // Unused code stops the clock
    endcase
    case (csot_pkg::csot_src_t'(timer_cfg[1:0]))
      csot_pkg::SRC_XTAL: itmr_src = src_xtal;
      csot_pkg::SRC_FAST: itmr_src = src_fast;
      csot_pkg::SRC_SLOW: itmr_src = src_slow;
      default:            itmr_src = cap_tick;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      cap_tick <= 1'b0;
    else
      cap_tick <= next_cap_tick;
  end

  csot_tick_div #(.W(8)) u_cpu_div (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_tick    (cpu_src),
    .i_divisor (cpu_divisor),
    .o_tick    (cpu_tick)
  );

  csot_tick_div #(.W(2)) u_sbus_div (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_tick    (sbus_src),
    .i_divisor (sbus_nodiv ? 2'h1 : 2'h2),
    .o_tick    (sbus_tick)
  );

  csot_tick_div #(.W(3)) u_itmr_div (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_tick    (itmr_src),
    .i_divisor (itmr_divisor),
    .o_tick    (itmr_tick)
  );

  assign o_ticks = '{processor: cpu_tick, serial_bus: sbus_tick,
                     interval: itmr_tick, capture: cap_tick};

  // Clock output pin; source swaps only while the pin is low
  logic [1:0] out_sel;
  logic [1:0] next_out_sel;
  logic       out_src;
  logic       next_pin;
  always_comb
  begin
    next_out_sel = out_sel;
    if (!o_clock_output_pin)
      next_out_sel = timer_cfg[7:6];
    case (csot_pkg::csot_src_t'(out_sel))
      csot_pkg::SRC_XTAL: out_src = filt_edge; // Filtered external input
      csot_pkg::SRC_FAST: out_src = src_fast;
      csot_pkg::SRC_SLOW: out_src = src_slow;
      default:            out_src = cpu_tick;
    endcase
    next_pin = o_clock_output_pin ^ out_src;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      out_sel               <= 2'h0;
      o_clock_output_pin    <= 1'b0;
      o_clock_output_pin_oe <= 1'b0;
      o_table_busy          <= 1'b0;
    end
    else
    begin
      out_sel               <= next_out_sel;
      o_clock_output_pin    <= next_pin;
      o_clock_output_pin_oe <= ~aux_cfg[csot_pkg::AUX_XTAL_PIN_BIT];
      o_table_busy          <= (next_state == csot_pkg::ST_COPY);
    end
  end

  assign o_fast_osc_trim = fast_trim; // Drives the fast oscillator macro
  assign o_slow_osc_trim = slow_trim; // Drives the slow oscillator macro
endmodule : csot_clock_select

/* design/csot_pkg.sv */
// Purpose: Shared constants and types for the clock select and oscillator trim block
// Assumes: 10 MHz system clock, 8-bit register port
// Notes:   Offsets are byte addresses on the register port
package csot_pkg;
  // System clock and slow oscillator rate
  localparam int CLK_SYS_HZ    = 10_000_000;
  localparam int SLOW_OSC_HZ   = 32_000;
  localparam int SLOW_DIV_CYC  = CLK_SYS_HZ / SLOW_OSC_HZ;
  localparam int FAST_OSC_HZ   = 24_000_000;

  // Register offsets
  localparam logic [7:0] ADDR_CPU_CFG    = 8'h30;
  localparam logic [7:0] ADDR_FAST_TRIM  = 8'h34;
  localparam logic [7:0] ADDR_SLOW_TRIM  = 8'h36;
  localparam logic [7:0] ADDR_TIMER_CFG  = 8'h38;
  localparam logic [7:0] ADDR_AUX_CFG    = 8'h39;
  localparam logic [7:0] ADDR_STATUS     = 8'h3a;
  localparam logic [7:0] ADDR_CALL       = 8'h3b;
  localparam logic [7:0] ADDR_PARAM_BASE = 8'hf8;

  // Field positions in the processor and serial bus config register
  localparam int CPU_SEL_BIT     = 0;
  localparam int SBUS_SEL_BIT    = 5;
  localparam int SBUS_NODIV_BIT  = 6;
  // Field positions in the aux config register
  localparam int AUX_FILT_BIT    = 3;
  localparam int AUX_XTAL_PIN_BIT = 4;
  // Reserved processor divider exponent
  localparam logic [2:0] CPU_DIV_RESERVED = 3'h6;

  // Supervisory call
  localparam logic [7:0] SUPERVISORY_KEY = 8'h3a;
  localparam logic [7:0] OP_TABLE_READ   = 8'h06;
  localparam int PARAM_BYTES  = 8;
  localparam int KEY_IDX      = 0;
  localparam int TABLE_SEL_IDX = 2;

  // Values after reset
  localparam logic [7:0] CPU_CFG_RST   = 8'h00;
  localparam logic [7:0] TIMER_CFG_RST = 8'h00;
  localparam logic [7:0] AUX_CFG_RST   = 8'h00;
  localparam logic [7:0] TRIM_RST      = 8'h00;

  // Clock source codes
  typedef enum logic [1:0] {
    SRC_XTAL = 2'h0,
    SRC_FAST = 2'h1,
    SRC_SLOW = 2'h2,
    SRC_ALT  = 2'h3
  } csot_src_t;

  typedef struct packed {
    logic [2:0] foffset;
    logic [4:0] gain;
  } csot_fast_trim_t;

  typedef struct packed {
    logic       low_power;
    logic       reserved;
    logic [1:0] bias;
    logic [3:0] freq;
  } csot_slow_trim_t;

  typedef struct packed {
    logic processor;
    logic serial_bus;
    logic interval;
    logic capture;
  } csot_ticks_t;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_COPY = 3'b100
  } csot_state_t;
endpackage : csot_pkg

/* design/csot_tick_div.sv */
// Purpose: Divides a one-cycle enable stream by a programmable count
// Assumes: Input ticks are one cycle long and on the system clock
// Notes:   A new divisor takes effect only at a terminal count
`timescale 1ns/1ns
module csot_tick_div #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  // Source enable and divisor
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_divisor,
  // Divided enable
  output logic              o_tick
);
  initial
  begin
    if (W < 1 || W > 16)
      $error("csot_tick_div: W out of range");
  end

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic [W-1:0] div_applied;
  logic [W-1:0] next_div_applied;
  logic         next_tick;

  // Count source ticks; divisor 0 acts as 1
  always_comb
  begin
    next_cnt         = cnt;
    next_div_applied = div_applied;
    next_tick        = 1'b0;
    if (i_tick)
    begin
      if (cnt + W'(1) >= div_applied || div_applied == '0)
      begin
        next_cnt         = '0;
        next_tick        = 1'b1;
        next_div_applied = i_divisor; // Swap only at the boundary
      end
      else
        next_cnt = cnt + W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt         <= '0;
      div_applied <= W'(1);
      o_tick      <= 1'b0;
    end
    else
    begin
      cnt         <= next_cnt;
      div_applied <= next_div_applied;
      o_tick      <= next_tick;
    end
  end
endmodule : csot_tick_div

/* tb/csot_clock_select_props.sv */
// Purpose: Port-level checks for csot_clock_select
// Assumes: Firmware never writes registers during the boot cycle
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
module csot_clock_select_props (
  // Clock, reset and register port
  input wire logic                      i_clk_sys,
  input wire logic                      i_reset,
  input wire logic [7:0]                i_addr,
  input wire logic [7:0]                i_wdata,
  input wire logic                      i_wr,
  input wire logic                      i_rd,
  // Observed outputs
  input wire logic [7:0]                o_rdata,
  input wire logic                      o_slow_tick,
  input wire logic                      o_wakeup,
  input wire logic                      o_clock_output_pin_oe,
  input wire csot_pkg::csot_fast_trim_t o_fast_osc_trim,
  input wire csot_pkg::csot_slow_trim_t o_slow_osc_trim,
  input wire logic                      o_table_busy
);
  localparam int SLOW_LAST = csot_pkg::SLOW_DIV_CYC - 1;
  logic [9:0] gap;
  logic [9:0] next_gap;
  logic       seen;
  logic       next_seen;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Cycles since the last slow tick; the first tick after reset has no reference
  always_comb
  begin
    next_gap  = o_slow_tick ? 10'h000 : gap + 10'h001;
    next_seen = seen | o_slow_tick;
  end
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      gap  <= 10'h000;
      seen <= 1'b0;
    end
    else
    begin
      gap  <= next_gap;
      seen <= next_seen;
    end
  end
  a_slow_period: assert property (o_slow_tick && seen |-> gap == 10'(SLOW_LAST))
    else $error("slow tick spacing wrong");
  a_wake_on_slow: assert property (o_wakeup |-> o_slow_tick || $past(o_slow_tick))
    else $error("wakeup not aligned to slow tick");
  a_copy_length: assert property ($rose(o_table_busy) |-> o_table_busy [*8] ##1 !o_table_busy)
    else $error("table copy length wrong");
  a_copy_cause: assert property ($rose(o_table_busy) |->
    $past(i_wr && i_addr == csot_pkg::ADDR_CALL && i_wdata == csot_pkg::OP_TABLE_READ))
    else $error("table copy without call");
  a_fast_trim_wr: assert property (i_wr && i_addr == csot_pkg::ADDR_FAST_TRIM
    && !o_table_busy |=> o_fast_osc_trim == $past(i_wdata))
    else $error("fast trim write lost");
  a_slow_trim_wr: assert property (i_wr
    && i_addr == csot_pkg::ADDR_SLOW_TRIM && !o_table_busy
    |=> o_slow_osc_trim == {$past(i_wdata[7]), 1'b0, $past(i_wdata[5:0])})
    else $error("slow trim write lost");
  a_slow_reserved: assert property (o_slow_osc_trim.reserved == 1'b0)
    else $error("slow trim reserved bit set");
  a_rd_reserved: assert property ($past(i_rd && i_addr == csot_pkg::ADDR_SLOW_TRIM)
    |-> o_rdata[6] == 1'b0)
    else $error("slow trim reserved bit read as one");
  a_pin_release: assert property (i_wr && i_addr == csot_pkg::ADDR_AUX_CFG && i_wdata[4]
    && !o_table_busy |-> ##[1:2] !o_clock_output_pin_oe)
    else $error("clock pin still driven");
endmodule : csot_clock_select_props

/* tb/csot_clock_select_tb.sv */
// Purpose: Self-checking bench for csot_clock_select
// Assumes: Source pins toggle with periods of 4, 6 and 10 system cycles
// Notes:   Wakeup count shortened to 4 slow ticks
`timescale 1ns/1ns
module csot_clock_select_tb;
  localparam logic [15:0] SID = 16'hc3e1; // Arbitrary identifier
  logic                      i_clk_sys;
  logic                      i_reset;
  logic [7:0]                i_addr;
  logic [7:0]                i_wdata;
  logic                      i_wr;
  logic                      i_rd;
  logic                      i_fast_osc;
  logic                      i_ext_crystal;
  logic                      i_external_clock_input;
  logic                      i_sleep;
  logic [7:0]                o_rdata;
  csot_pkg::csot_ticks_t     o_ticks;
  logic                      o_slow_tick;
  logic                      o_wakeup;
  logic                      o_clock_output_pin;
  logic                      o_clock_output_pin_oe;
  csot_pkg::csot_fast_trim_t o_fast_osc_trim;
  csot_pkg::csot_slow_trim_t o_slow_osc_trim;
  logic                      o_table_busy;
  logic [7:0]                d;
  logic [7:0]                e;
  int                        pc;
  int                        error_cnt;
  int                        n_tests;
  logic [1:0]                bias [3] = '{2'h0, 2'h1, 2'h3};
  int                        ns [7] = '{0, 1, 2, 3, 4, 5, 7};

  csot_clock_select #(.SILICON_ID(SID), .FAST_TRIM_CAL(8'hf3), .SLOW_TRIM_CAL(8'h7c),
    .WAKE_SLOW_TICKS(4)) uut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fast_osc(i_fast_osc),
    .i_ext_crystal(i_ext_crystal), .i_external_clock_input(i_external_clock_input),
    .i_sleep(i_sleep), .o_ticks(o_ticks), .o_slow_tick(o_slow_tick), .o_wakeup(o_wakeup),
    .o_clock_output_pin(o_clock_output_pin), .o_clock_output_pin_oe(o_clock_output_pin_oe),
    .o_fast_osc_trim(o_fast_osc_trim), .o_slow_osc_trim(o_slow_osc_trim),
    .o_table_busy(o_table_busy));

  // System clock, 100 ns period
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // Source pins; periods all differ so selection errors show as wrong spacing
  always @(posedge i_clk_sys)
  begin
    pc <= (pc == 59) ? 0 : pc + 1;
    i_fast_osc <= pc[1];
    i_ext_crystal <= (pc % 6) < 3;
    i_external_clock_input <= (pc % 10) < 5;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rc

  // Spacing of pulses 2 and 3, skipping the period that straddles a change
  task automatic meas(input int k, input int exp);
    int n, t, t0;
    logic pp;
    logic [6:0] m;
    n = 0;
    t = 0;
    t0 = 0;
    pp = o_clock_output_pin;
    for (int i = 0; i < 4000 && n < 3; i++)
    begin
      @(posedge i_clk_sys);
      #1 m = {o_wakeup, o_slow_tick, o_ticks, o_clock_output_pin & ~pp};
      pp = o_clock_output_pin;
      if (m[k])
      begin
        n++;
        t0 = t;
        t = i;
      end
    end
    chk((n == 3) ? t - t0 : 0, exp);
  endtask : meas

  // Table read request; a fast trim write is issued while the copy runs
  task automatic tread(input logic [7:0] key, input logic [7:0] sel);
    int w;
    wr(8'hf8, key);
    wr(8'hf9, 8'h13);
    wr(8'hfa, sel);
    wr(csot_pkg::ADDR_CALL, csot_pkg::OP_TABLE_READ);
    wr(csot_pkg::ADDR_FAST_TRIM, 8'h00);
    w = 0;
    while (o_table_busy !== 1'b0 && w < 20)
    begin
      @(posedge i_clk_sys);
      w++;
    end
  endtask : tread

  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the expected run of about 20000 cycles
  initial
  begin
    #(60_000 * 100);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    {i_addr, i_wdata, i_wr, i_rd, i_sleep, i_fast_osc, i_ext_crystal} = '0;
    i_external_clock_input = 1'b0;
    pc = 0;
    error_cnt = 0;
    n_tests = 0;
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    // Factory values after boot, fine offset cleared
    rc(csot_pkg::ADDR_FAST_TRIM, 8'h13);
    rc(csot_pkg::ADDR_SLOW_TRIM, 8'h3c);
    wr(csot_pkg::ADDR_FAST_TRIM, 8'he5);
    rc(csot_pkg::ADDR_FAST_TRIM, 8'he5);
    rd(csot_pkg::ADDR_SLOW_TRIM, d);
    wr(csot_pkg::ADDR_SLOW_TRIM, d | 8'h80);
    rc(csot_pkg::ADDR_SLOW_TRIM, 8'hbc);
    foreach (bias[i])
    begin
      wr(csot_pkg::ADDR_SLOW_TRIM, {2'h3, bias[i], 4'(i * 5 + 3)});
      rc(csot_pkg::ADDR_SLOW_TRIM, {2'h2, bias[i], 4'(i * 5 + 3)});
    end
    // Unmapped address reads as zero
    rc(8'h20, 8'h00);
    tread(csot_pkg::SUPERVISORY_KEY, 8'hf8);
    for (int i = 0; i < 8; i++)
      rc(8'hf8 + 8'(i), (i == 0) ? SID[15:8] : (i == 1) ? SID[7:0] : 8'h00);
    rc(csot_pkg::ADDR_FAST_TRIM, 8'he5);
    tread(csot_pkg::SUPERVISORY_KEY, 8'h05);
    for (int i = 0; i < 8; i++)
      rc(8'hf8 + 8'(i), 8'h00);
    // Wrong key: no copy, so the trim write is taken
    tread(8'h3b, 8'h00);
    rc(8'hf8, 8'h3b);
    rc(csot_pkg::ADDR_FAST_TRIM, 8'h00);
    foreach (ns[i])
    begin
      wr(csot_pkg::ADDR_AUX_CFG, 8'(ns[i]));
      meas(4, 4 << ns[i]);
    end
    wr(csot_pkg::ADDR_AUX_CFG, 8'h06);
    meas(4, 512);
    rc(csot_pkg::ADDR_AUX_CFG, 8'h07);
    wr(csot_pkg::ADDR_AUX_CFG, 8'h00);
    wr(csot_pkg::ADDR_CPU_CFG, 8'h01);
    meas(4, 6);
    meas(3, 8);
    wr(csot_pkg::ADDR_CPU_CFG, 8'h61);
    meas(3, 6);
    wr(csot_pkg::ADDR_CPU_CFG, 8'h21);
    meas(3, 12);
    rc(csot_pkg::ADDR_CPU_CFG, 8'h21);
    for (int p = 0; p < 4; p++)
    begin
      wr(csot_pkg::ADDR_TIMER_CFG, 8'(p << 2));
      meas(2, 6 * (p + 1));
      wr(csot_pkg::ADDR_TIMER_CFG, 8'(p << 2 | 1));
      meas(2, 4 * (p + 1));
    end
    wr(csot_pkg::ADDR_TIMER_CFG, 8'h17);
    meas(1, 4);
    meas(2, 8);
    wr(csot_pkg::ADDR_TIMER_CFG, 8'h22);
    rc(csot_pkg::ADDR_TIMER_CFG, 8'h22);
    meas(1, csot_pkg::SLOW_DIV_CYC);
    meas(2, csot_pkg::SLOW_DIV_CYC);
    @(posedge i_clk_sys) i_sleep <= 1'b1;
    meas(1, 0);
    meas(2, 0);
    // Status carries a live pin level, so reread until two reads agree
    rd(csot_pkg::ADDR_STATUS, e);
    do
    begin
      d = e;
      rd(csot_pkg::ADDR_STATUS, e);
    end
    while (e !== d);
    chk(d[2:0], 3'h4);
    meas(5, csot_pkg::SLOW_DIV_CYC);
    @(posedge i_clk_sys) i_sleep <= 1'b0;
    meas(6, 4 * csot_pkg::SLOW_DIV_CYC);
    wr(csot_pkg::ADDR_TIMER_CFG, 8'h40);
    meas(0, 8);
    wr(csot_pkg::ADDR_TIMER_CFG, 8'h00);
    meas(0, 20);
    // Filter on: clean edges pass, one cycle later
    wr(csot_pkg::ADDR_AUX_CFG, 8'h08);
    meas(0, 20);
    wr(csot_pkg::ADDR_TIMER_CFG, 8'hc0);
    meas(0, 12);
    wr(csot_pkg::ADDR_TIMER_CFG, 8'h80);
    meas(0, 2 * csot_pkg::SLOW_DIV_CYC);
    chk(o_clock_output_pin_oe, 1'b1);
    wr(csot_pkg::ADDR_AUX_CFG, 8'h10);
    repeat (2) @(posedge i_clk_sys);
    chk(o_clock_output_pin_oe, 1'b0);
    end_of_test();
  end
endmodule : csot_clock_select_tb

bind csot_clock_select csot_clock_select_props u_props (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_slow_tick(o_slow_tick),
  .o_wakeup(o_wakeup), .o_clock_output_pin_oe(o_clock_output_pin_oe),
  .o_fast_osc_trim(o_fast_osc_trim), .o_slow_osc_trim(o_slow_osc_trim),
  .o_table_busy(o_table_busy));
